/* File: csil_cfg.svh */
// constants of the core status and interrupt logic: offsets, bit positions,
// vectors and reset values; assumes it is included by bare name, definitions only
`ifndef CSIL_CFG_SVH
`define CSIL_CFG_SVH

// ==========================================================================
// data memory locations of the special registers
`define CSIL_ADDR_WINDOW_ZERO 8'h00
`define CSIL_ADDR_POINTER_ZERO 8'h01
`define CSIL_ADDR_WINDOW_ONE 8'h02
`define CSIL_ADDR_POINTER_ONE 8'h03
`define CSIL_ADDR_ACCUMULATOR 8'h05
`define CSIL_ADDR_CORE_FLAGS 8'h0A
`define CSIL_ADDR_INTERRUPT_CONTROL 8'h0B

// ==========================================================================
// core_flags bit positions
`define CSIL_FLAG_CARRY 0
`define CSIL_FLAG_HALF_CARRY 1
`define CSIL_FLAG_ZERO 2
`define CSIL_FLAG_OVERFLOW 3
`define CSIL_FLAG_POWER_DOWN 4
`define CSIL_FLAG_WATCHDOG 5

// ==========================================================================
// interrupt_control bit positions
`define CSIL_IC_GLOBAL_EN 0
`define CSIL_IC_PIN_EN 1
`define CSIL_IC_TIMER_EN 2
`define CSIL_IC_CONV_EN 3
`define CSIL_IC_PIN_PEND 4
`define CSIL_IC_TIMER_PEND 5
`define CSIL_IC_CONV_PEND 6
`define CSIL_IC_TEST 7

// ==========================================================================
// service vectors and reset values
`define CSIL_VECTOR_PIN 12'h004
`define CSIL_VECTOR_TIMER 12'h008
`define CSIL_VECTOR_CONV 12'h00C
`define CSIL_RESET_BYTE 8'h00
`define CSIL_RESET_VECTOR 12'h000

`endif

/* File: csil_pkg.sv */
// types shared by the core status and interrupt logic and its users;
// assumes the constants header is compiled alongside
`default_nettype none

package csil_pkg;

	// ======================================================================
	// operations the sequencer asks of the arithmetic unit
	typedef enum logic [4:0] {
		CSIL_OP_LOAD,
		CSIL_OP_ADD,
		CSIL_OP_ADC,
		CSIL_OP_SUB,
		CSIL_OP_SBC,
		CSIL_OP_DAA,
		CSIL_OP_AND,
		CSIL_OP_OR,
		CSIL_OP_XOR,
		CSIL_OP_CPL,
		CSIL_OP_RL,
		CSIL_OP_RR,
		CSIL_OP_RLC,
		CSIL_OP_RRC,
		CSIL_OP_INC,
		CSIL_OP_DEC
	} csil_alu_op_t;

	// ======================================================================
	// one data memory access from the sequencer
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csil_mem_req_t;

	// one arithmetic unit request
	typedef struct packed {
		logic go;
		csil_alu_op_t op;
		logic [7:0] operand;
	} csil_alu_req_t;

	// single-cycle core events from sequencer, watchdog, timer and converter
	typedef struct packed {
		logic halt_exec;
		logic watchdog_clear_instr;
		logic watchdog_expire;
		logic timer_overflow;
		logic conversion_done;
		logic return_from_irq;
	} csil_events_t;

endpackage

`default_nettype wire

/* File: csil_core.sv */
// special-function registers, arithmetic unit flags and interrupt unit of the core
// assumes a sequencer that issues one memory access and one arithmetic request per cycle,
// owns the return stack and reports whether it is full, and marks acknowledge slots
`timescale 1ns/1ps
`default_nettype none
`include "csil_cfg.svh"

// Overview of operation
// - windows redirect through pointer zero, one
// - window pointing at window reads zero
// - both pointers are eight bits wide
// - accumulator mapped in memory; moves pass it
// - eight-bit arithmetic, logic, rotate, skip operations
// - flag bit layout; bits six, seven zero
// - flag writes touch arithmetic flags only
// - carry from add, no-borrow, rotates through carry
// - half carry from low nibble
// - zero flag follows result equals zero
// - overflow is carry in xor out
// - power-down: clear reset/watchdog clear, set halt
// - watchdog flag: clear reset/clear/halt, set expiry
// - interrupt entry saves no flags
// - control enables at bits zero to three
// - pending at four to six; seven test
// - service entry clears global enable
// - full stack defers acknowledge until return
// - every source can wake from halt
// - pin falling edge, vector four
// - timer overflow, vector eight
// - conversion end, vector twelve
// - priority pin, then timer, then converter
// - interrupt return sets global enable
// - pending stays until serviced or cleared
module csil_core #(
	parameter int RAM_DEPTH = 256 // general data memory bytes behind the pointers
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire csil_pkg::csil_mem_req_t i_mem,
	input wire csil_pkg::csil_alu_req_t i_alu,
	input wire csil_pkg::csil_events_t i_evt,
	input wire logic i_ext_irq_pin,
	input wire logic i_stack_full,
	input wire logic i_irq_slot,
	output logic [7:0] o_rdata,
	output logic [7:0] o_accumulator,
	output logic [7:0] o_core_flags,
	output logic [7:0] o_interrupt_control,
	output logic o_skip,
	output logic o_irq_take,
	output logic [11:0] o_irq_vector,
	output logic o_wake
);

	// ======================================================================
	// storage
	logic [7:0] ram_q [RAM_DEPTH]; // general data memory, no reset
	logic [7:0] pointer_zero_q; // selects a byte for window zero
	logic [7:0] pointer_one_q; // selects a byte for window one
	logic [7:0] accum_q; // accumulator
	logic [3:0] arith_q; // overflow, zero, half carry, carry
	logic power_down_flag_q; // set by halt
	logic watchdog_expired_flag_q; // set by watchdog expiry
	logic [7:0] interrupt_control_q; // interrupt_control contents
	logic pin_prev_q; // last sample of the pin
	logic [7:0] rdata_q;
	logic skip_q;
	logic irq_take_q;
	logic [11:0] irq_vector_q;
	logic wake_q;

	// ======================================================================
	// address resolution
	// returns {null access, effective address}; used for reads and writes
	function automatic logic [8:0] resolve(input logic [7:0] addr, input logic [7:0] p0,
		input logic [7:0] p1);
		logic [7:0] eff;
		logic ind;
		eff = addr;
		ind = 1'b0;
		if (addr == `CSIL_ADDR_WINDOW_ZERO) begin
			eff = p0;
			ind = 1'b1;
		end else if (addr == `CSIL_ADDR_WINDOW_ONE) begin
			eff = p1;
			ind = 1'b1;
		end
		// a window that points at a window is a dead location
		return {ind && (eff == `CSIL_ADDR_WINDOW_ZERO || eff == `CSIL_ADDR_WINDOW_ONE), eff};
	endfunction

	logic [8:0] res;
	logic dead_access;
	logic [7:0] eff_addr;
	assign res = resolve(i_mem.addr, pointer_zero_q, pointer_one_q);
	assign dead_access = res[8];
	assign eff_addr = res[7:0];

	// write strobes per location
	logic wr_any;
	assign wr_any = i_mem.wr && !dead_access;
	logic wr_p0, wr_p1, wr_accum, wr_flags, wr_interrupt_control, wr_ram;
	assign wr_p0 = wr_any && eff_addr == `CSIL_ADDR_POINTER_ZERO;
	assign wr_p1 = wr_any && eff_addr == `CSIL_ADDR_POINTER_ONE;
	assign wr_accum = wr_any && eff_addr == `CSIL_ADDR_ACCUMULATOR;
	assign wr_flags = wr_any && eff_addr == `CSIL_ADDR_CORE_FLAGS;
	assign wr_interrupt_control = wr_any && eff_addr == `CSIL_ADDR_INTERRUPT_CONTROL;
	assign wr_ram = wr_any && !wr_p0 && !wr_p1 && !wr_accum && !wr_flags && !wr_interrupt_control;

	// flags as read back; bits six and seven are zero
	logic [7:0] flags_view;
	assign flags_view = {2'b00, watchdog_expired_flag_q, power_down_flag_q, arith_q};

	// ======================================================================
	// arithmetic unit
	logic [7:0] alu_res; // result into the accumulator
	logic [3:0] alu_flags; // new {overflow, zero, half carry, carry}
	logic [3:0] alu_mask; // which flags this operation loads
	logic [7:0] opb; // second operand after inversion for subtraction
	logic cin; // carry into bit zero
	logic [8:0] sum9;
	logic [4:0] sum_lo;
	logic [7:0] sum_lo7;
	logic [8:0] daa_t;
	always_comb begin
		opb = i_alu.operand;
		cin = 1'b0;
		// subtraction adds the complement; carry then means no borrow
		unique case (i_alu.op)
			csil_pkg::CSIL_OP_SUB: begin
				opb = ~i_alu.operand;
				cin = 1'b1;
			end
			csil_pkg::CSIL_OP_SBC: begin
				opb = ~i_alu.operand;
				cin = arith_q[`CSIL_FLAG_CARRY];
			end
			csil_pkg::CSIL_OP_ADC: cin = arith_q[`CSIL_FLAG_CARRY];
			default: cin = 1'b0;
		endcase
		sum9 = {1'b0, accum_q} + {1'b0, opb} + {8'h00, cin};
		sum_lo = {1'b0, accum_q[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
		sum_lo7 = {1'b0, accum_q[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
		// decimal adjust: add six to each nibble that left the decimal range
		daa_t = {1'b0, accum_q};
		if (accum_q[3:0] > 4'h9 || arith_q[`CSIL_FLAG_HALF_CARRY]) begin
			daa_t = daa_t + 9'h006;
		end
		if (daa_t[7:4] > 4'h9 || daa_t[8] || arith_q[`CSIL_FLAG_CARRY]) begin
			daa_t = daa_t + 9'h060;
		end
		alu_res = sum9[7:0];
		alu_flags = arith_q;
		alu_mask = 4'h0;
		unique case (i_alu.op)
			csil_pkg::CSIL_OP_LOAD: alu_res = i_alu.operand;
			csil_pkg::CSIL_OP_ADD, csil_pkg::CSIL_OP_ADC, csil_pkg::CSIL_OP_SUB,
			csil_pkg::CSIL_OP_SBC: begin
				alu_flags[`CSIL_FLAG_CARRY] = sum9[8];
				alu_flags[`CSIL_FLAG_HALF_CARRY] = sum_lo[4];
				alu_flags[`CSIL_FLAG_OVERFLOW] = sum_lo7[7] ^ sum9[8];
				alu_mask = 4'hF;
			end
			csil_pkg::CSIL_OP_DAA: begin
				alu_res = daa_t[7:0];
				alu_flags[`CSIL_FLAG_CARRY] = daa_t[8] || arith_q[`CSIL_FLAG_CARRY];
				alu_mask = 4'h1;
			end
			csil_pkg::CSIL_OP_AND: begin
				alu_res = accum_q & i_alu.operand;
				alu_mask = 4'h4;
			end
			csil_pkg::CSIL_OP_OR: begin
				alu_res = accum_q | i_alu.operand;
				alu_mask = 4'h4;
			end
			csil_pkg::CSIL_OP_XOR: begin
				alu_res = accum_q ^ i_alu.operand;
				alu_mask = 4'h4;
			end
			csil_pkg::CSIL_OP_CPL: begin
				alu_res = ~i_alu.operand;
				alu_mask = 4'h4;
			end
			csil_pkg::CSIL_OP_RL: alu_res = {i_alu.operand[6:0], i_alu.operand[7]};
			csil_pkg::CSIL_OP_RR: alu_res = {i_alu.operand[0], i_alu.operand[7:1]};
			csil_pkg::CSIL_OP_RLC: begin
				alu_res = {i_alu.operand[6:0], arith_q[`CSIL_FLAG_CARRY]};
				alu_flags[`CSIL_FLAG_CARRY] = i_alu.operand[7];
				alu_mask = 4'h1;
			end
			csil_pkg::CSIL_OP_RRC: begin
				alu_res = {arith_q[`CSIL_FLAG_CARRY], i_alu.operand[7:1]};
				alu_flags[`CSIL_FLAG_CARRY] = i_alu.operand[0];
				alu_mask = 4'h1;
			end
			csil_pkg::CSIL_OP_INC: begin
				alu_res = i_alu.operand + 8'h01;
				alu_mask = 4'h4;
			end
			csil_pkg::CSIL_OP_DEC: begin
				alu_res = i_alu.operand - 8'h01;
				alu_mask = 4'h4;
			end
		endcase
		// zero flag follows every arithmetic and logic result
		alu_flags[`CSIL_FLAG_ZERO] = (alu_res == 8'h00);
	end

	// ======================================================================
	// pointers: plain eight-bit registers
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			pointer_zero_q <= `CSIL_RESET_BYTE;
			pointer_one_q <= `CSIL_RESET_BYTE;
		end else begin
			if (wr_p0) begin
				pointer_zero_q <= i_mem.wdata;
			end
			if (wr_p1) begin
				pointer_one_q <= i_mem.wdata;
			end
		end
	end

	// accumulator: arithmetic result wins over a memory write in the same cycle
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			accum_q <= `CSIL_RESET_BYTE;
		end else if (i_alu.go) begin
			accum_q <= alu_res;
		end else if (wr_accum) begin
			accum_q <= i_mem.wdata;
		end
	end

	// arithmetic flags: a write loads all four, then the unit overrides its own
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			arith_q <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (i_alu.go && (alu_mask[i] || i == `CSIL_FLAG_ZERO)) begin
					arith_q[i] <= alu_flags[i];
				end else if (wr_flags) begin
					arith_q[i] <= i_mem.wdata[i];
				end
			end
		end
	end

	// power-down and watchdog flags: never written by software
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			power_down_flag_q <= 1'b0;
			watchdog_expired_flag_q <= 1'b0;
		end else begin
			if (i_evt.halt_exec) begin
				power_down_flag_q <= 1'b1;
			end else if (i_evt.watchdog_clear_instr) begin
				power_down_flag_q <= 1'b0;
			end
			// expiry is a set and wins over a clear in the same cycle
			if (i_evt.watchdog_expire) begin
				watchdog_expired_flag_q <= 1'b1;
			end else if (i_evt.halt_exec || i_evt.watchdog_clear_instr) begin
				watchdog_expired_flag_q <= 1'b0;
			end
		end
	end

	// general data memory
	always_ff @(posedge i_mclk) begin
		if (wr_ram && int'(eff_addr) < RAM_DEPTH) begin
			ram_q[eff_addr] <= i_mem.wdata;
		end
	end

	// registered read data; dead window and unimplemented bytes read zero
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			rdata_q <= `CSIL_RESET_BYTE;
		end else if (i_mem.rd) begin
			if (dead_access) begin
				rdata_q <= 8'h00;
			end else begin
				unique case (eff_addr)
					`CSIL_ADDR_POINTER_ZERO: rdata_q <= pointer_zero_q;
					`CSIL_ADDR_POINTER_ONE: rdata_q <= pointer_one_q;
					`CSIL_ADDR_ACCUMULATOR: rdata_q <= accum_q;
					`CSIL_ADDR_CORE_FLAGS: rdata_q <= flags_view;
					`CSIL_ADDR_INTERRUPT_CONTROL: rdata_q <= interrupt_control_q;
					default: rdata_q <= (int'(eff_addr) < RAM_DEPTH) ? ram_q[eff_addr] : 8'h00;
				endcase
			end
		end
	end

	// skip decision for the sequencer: result of the last operation was zero
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			skip_q <= 1'b0;
		end else if (i_alu.go) begin
			skip_q <= (alu_res == 8'h00);
		end
	end

	// ======================================================================
	// interrupt unit
	logic pin_fall; // falling edge of the interrupt pin
	logic [2:0] pend_set; // {converter, timer, pin} events this cycle
	logic [2:0] armed; // pending and source enabled
	logic [2:0] grant; // one-hot choice by priority
	logic take; // acknowledge in this slot
	logic [11:0] take_vec;
	assign pin_fall = pin_prev_q && !i_ext_irq_pin;
	assign pend_set = {i_evt.conversion_done, i_evt.timer_overflow, pin_fall};
	assign armed = interrupt_control_q[`CSIL_IC_CONV_PEND:`CSIL_IC_PIN_PEND] & interrupt_control_q[`CSIL_IC_CONV_EN:`CSIL_IC_PIN_EN];
	// lowest bit first: pin, then timer, then converter
	assign grant = armed & (~armed + 3'b001);
	// a full stack holds the request until a return frees a level
	assign take = i_irq_slot && interrupt_control_q[`CSIL_IC_GLOBAL_EN] && (|armed) && !i_stack_full;
	always_comb begin
		unique case (1'b1)
			grant[0]: take_vec = `CSIL_VECTOR_PIN;
			grant[1]: take_vec = `CSIL_VECTOR_TIMER;
			grant[2]: take_vec = `CSIL_VECTOR_CONV;
			default: take_vec = `CSIL_RESET_VECTOR;
		endcase
	end

	// pin sample for edge detection
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			pin_prev_q <= 1'b1;
		end else begin
			pin_prev_q <= i_ext_irq_pin;
		end
	end

	// interrupt_control: software write, then service clear, then hardware set
	always_ff @(posedge i_mclk) begin
		logic [7:0] nxt;
		nxt = interrupt_control_q;
		if (i_reset) begin
			interrupt_control_q <= `CSIL_RESET_BYTE;
		end else begin
			if (wr_interrupt_control) begin
				nxt = i_mem.wdata;
			end
			if (take) begin
				nxt[`CSIL_IC_GLOBAL_EN] = 1'b0;
				nxt[`CSIL_IC_CONV_PEND:`CSIL_IC_PIN_PEND] = nxt[`CSIL_IC_CONV_PEND:`CSIL_IC_PIN_PEND] & ~grant;
			end
			if (i_evt.return_from_irq) begin
				nxt[`CSIL_IC_GLOBAL_EN] = 1'b1;
			end
			// new events win over any clear; disabling never erases a flag
			nxt[`CSIL_IC_CONV_PEND:`CSIL_IC_PIN_PEND] = nxt[`CSIL_IC_CONV_PEND:`CSIL_IC_PIN_PEND] | pend_set;
			interrupt_control_q <= nxt;
		end
	end

	// acknowledge pulse and vector; only the sequencer pushes the program counter
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			irq_take_q <= 1'b0;
			irq_vector_q <= `CSIL_RESET_VECTOR;
		end else begin
			irq_take_q <= take;
			if (take) begin
				irq_vector_q <= take_vec;
			end
		end
	end

	// wake request: any enabled source with its flag set, global enable aside
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= |armed;
		end
	end

	// ======================================================================
	// outputs
	assign o_rdata = rdata_q;
	assign o_accumulator = accum_q;
	assign o_core_flags = flags_view;
	assign o_interrupt_control = interrupt_control_q;
	assign o_skip = skip_q;
	assign o_irq_take = irq_take_q;
	assign o_irq_vector = irq_vector_q;
	assign o_wake = wake_q;

endmodule

`default_nettype wire

/* File: csil_core_props.sv */
// assertions on the ports of the core status and interrupt logic
// assumes a bind onto csil_core from the testbench top file
`timescale 1ns/1ps
`default_nettype none

module csil_core_props #(
	parameter int RAM_DEPTH = 256
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire csil_pkg::csil_mem_req_t i_mem,
	input wire csil_pkg::csil_alu_req_t i_alu,
	input wire csil_pkg::csil_events_t i_evt,
	input wire logic i_ext_irq_pin,
	input wire logic i_stack_full,
	input wire logic i_irq_slot,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] o_accumulator,
	input wire logic [7:0] o_core_flags,
	input wire logic [7:0] o_interrupt_control,
	input wire logic o_skip,
	input wire logic o_irq_take,
	input wire logic [11:0] o_irq_vector,
	input wire logic o_wake
);
	// ==========================================
	// short view of the control register
	logic [7:0] ic;
	assign ic = o_interrupt_control;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	// ==========================================
	// interrupt acceptance and vectoring
	chk_take_has_cause: assert property (o_irq_take |-> $past(i_irq_slot && ic[0] && !i_stack_full &&
		|(ic[6:4] & ic[3:1]))) else $error("take without an enabled pending source");
	chk_take_drops_global: assert property (o_irq_take && !$past(i_evt.return_from_irq) |-> !ic[0])
		else $error("global enable still set after take");
	chk_pin_vector: assert property (o_irq_take && $past(ic[4] & ic[1]) |-> o_irq_vector == 12'h004)
		else $error("pin take without vector 004");
	chk_timer_vector: assert property (o_irq_take && $past(!(ic[4] & ic[1]) && ic[5] & ic[2]) |->
		o_irq_vector == 12'h008) else $error("timer take without vector 008");
	chk_conv_vector: assert property (o_irq_take && $past(ic[6:4] & ic[3:1]) == 3'b100 |->
		o_irq_vector == 12'h00C) else $error("converter take without vector 00C");
	chk_full_blocks_take: assert property (i_stack_full |=> !o_irq_take)
		else $error("take while the stack was full");
	chk_return_from_irq_sets_global: assert property ($past(i_evt.return_from_irq && !i_mem.wr && !i_reset) |-> ic[0])
		else $error("interrupt return left global enable clear");
	chk_pending_holds: assert property ($fell(ic[5]) |-> o_irq_take || $past(i_mem.wr || i_reset))
		else $error("timer pending dropped without cause");

	// ==========================================
	// flags and accumulator
	chk_flags_top_zero: assert property (o_core_flags[7:6] == 2'b00)
		else $error("unused flag bits not zero");
	chk_halt_flags: assert property ($past(i_evt.halt_exec && !i_evt.watchdog_expire && !i_reset) |->
		o_core_flags[5:4] == 2'b01) else $error("halt did not set power-down and clear expiry");
	chk_expire_sets: assert property ($past(i_evt.watchdog_expire && !i_reset) |-> o_core_flags[5])
		else $error("expiry flag not set");
	chk_acc_read_back: assert property ($past(i_mem.rd && !i_mem.wr && !i_alu.go && !i_reset &&
		i_mem.addr == 8'h05) |-> o_rdata == $past(o_accumulator)) else $error("accumulator read mismatch");
endmodule

`default_nettype wire

/* File: csil_seq_model.sv */
// behavioural sequencer: return stack depth and interrupt slot
// assumes pushes come from takes and calls, pops from the bench
`timescale 1ns/1ps
`default_nettype none

module csil_seq_model #(
	parameter int DEPTH = 6 // return stack levels
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_take,
	input wire logic i_call,
	input wire logic i_pop,
	input wire logic i_stall,
	output logic o_stack_full,
	output logic o_irq_slot
);
	// ==========================================
	// stack holds program counters only, so only depth is kept
	logic [3:0] depth_q;
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			depth_q <= 4'h0;
		end else if ((i_take || i_call) && !i_pop && depth_q != 4'(DEPTH)) begin
			depth_q <= depth_q + 4'h1;
		end else if (i_pop && !i_take && !i_call && depth_q != 4'h0) begin
			depth_q <= depth_q - 4'h1;
		end
	end
	// full flag gates acceptance; a stall models a slow sequencer
	assign o_stack_full = depth_q == 4'(DEPTH);
	assign o_irq_slot = !i_stall;
endmodule

`default_nettype wire

/* File: tb_core_status_and_interrupt_logic.sv */
// self-checking bench for the core status and interrupt logic
// assumes csil_core, its checker and the sequencer model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_core_status_and_interrupt_logic;
	// ==========================================
	// stimulus, observed outputs and counters
	logic i_mclk, i_reset, i_ext_irq_pin, stall, call, pop, full, slot, skip, take, wake;
	csil_pkg::csil_mem_req_t i_mem;
	csil_pkg::csil_alu_req_t i_alu;
	csil_pkg::csil_events_t i_evt;
	logic [7:0] rdata, accum, flags, ic;
	logic [11:0] vec;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;

	csil_core csil_core_inst (.i_mclk(i_mclk), .i_reset(i_reset), .i_mem(i_mem), .i_alu(i_alu),
		.i_evt(i_evt), .i_ext_irq_pin(i_ext_irq_pin), .i_stack_full(full), .i_irq_slot(slot),
		.o_rdata(rdata), .o_accumulator(accum), .o_core_flags(flags), .o_interrupt_control(ic),
		.o_skip(skip), .o_irq_take(take), .o_irq_vector(vec), .o_wake(wake));
	csil_seq_model csil_seq_model_inst (.i_mclk(i_mclk), .i_reset(i_reset), .i_take(take), .i_call(call),
		.i_pop(pop), .i_stall(stall), .o_stack_full(full), .o_irq_slot(slot));

	// ==========================================
	// clock and hang limit
	always #50 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end

	// ==========================================
	// shared drivers and comparison
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_mclk);
	endtask
	// every driver leaves one idle edge before the next request
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_mem = {2'b01, a, d};
		cyc(1);
		i_mem = '0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_mem = {2'b10, a, 8'h00};
		cyc(1);
		i_mem = '0;
		cyc(1);
		chk(rdata, e);
	endtask
	task automatic ev(input logic [5:0] e);
		i_evt = e;
		cyc(1);
		i_evt = '0;
		cyc(1);
	endtask
	task automatic go(input csil_pkg::csil_alu_op_t op, input logic [7:0] b);
		i_alu = {1'b1, op, b};
		cyc(1);
		i_alu = '0;
		cyc(1);
	endtask
	// wait a bounded time for the one-cycle take pulse
	task automatic wait_take(input logic [11:0] v);
		int n;
		n = 0;
		while (take !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk(take, 12'h001);
		chk(vec, v);
	endtask
	task automatic reset_dut();
		cyc(1);
		i_reset = 1'b1;
		cyc(12);
		i_reset = 1'b0;
	endtask

	// ==========================================
	// scenarios
	task automatic t_window();
		reset_dut();
		chk(flags, 8'h00);
		chk(ic, 8'h00);
		wr(8'h01, 8'h40);
		wr(8'h00, 8'hAA);
		rd(8'h40, 8'hAA);
		wr(8'h03, 8'hFF);
		wr(8'h02, 8'h5C);
		rd(8'hFF, 8'h5C);
		wr(8'h01, 8'h02);
		wr(8'h00, 8'h77);
		rd(8'h00, 8'h00);
		rd(8'h02, 8'h5C);
		wr(8'h05, 8'h3C);
		chk(accum, 8'h3C);
		rd(8'h05, 8'h3C);
	endtask
	// carry in is preset through a flag write, then the accumulator is loaded
	task automatic alu_case(input csil_pkg::csil_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
		input logic ci, input logic [7:0] e, input logic [3:0] ef, input logic [3:0] m);
		wr(8'h0A, {7'h00, ci});
		go(csil_pkg::CSIL_OP_LOAD, a);
		go(op, b);
		chk(accum, e);
		chk(flags[3:0] & m, ef & m);
		chk(skip, e == 8'h00);
	endtask
	task automatic t_alu();
		alu_case(csil_pkg::CSIL_OP_ADD, 8'h7F, 8'h01, 1'b0, 8'h80, 4'hA, 4'hF);
		alu_case(csil_pkg::CSIL_OP_ADC, 8'hFF, 8'h00, 1'b1, 8'h00, 4'h7, 4'hF);
		alu_case(csil_pkg::CSIL_OP_SUB, 8'h80, 8'h80, 1'b0, 8'h00, 4'h7, 4'hF);
		alu_case(csil_pkg::CSIL_OP_SBC, 8'h00, 8'h01, 1'b1, 8'hFF, 4'h0, 4'hF);
		alu_case(csil_pkg::CSIL_OP_DAA, 8'h9A, 8'h00, 1'b0, 8'h00, 4'h5, 4'h5);
		alu_case(csil_pkg::CSIL_OP_AND, 8'hF0, 8'h0F, 1'b0, 8'h00, 4'h4, 4'h4);
		alu_case(csil_pkg::CSIL_OP_OR, 8'hF0, 8'h0F, 1'b0, 8'hFF, 4'h0, 4'h4);
		alu_case(csil_pkg::CSIL_OP_XOR, 8'h5A, 8'h5A, 1'b0, 8'h00, 4'h4, 4'h4);
		alu_case(csil_pkg::CSIL_OP_CPL, 8'h00, 8'hFF, 1'b0, 8'h00, 4'h4, 4'h4);
		alu_case(csil_pkg::CSIL_OP_RL, 8'h00, 8'h81, 1'b0, 8'h03, 4'h0, 4'h0);
		alu_case(csil_pkg::CSIL_OP_RR, 8'h00, 8'h81, 1'b0, 8'hC0, 4'h0, 4'h0);
		alu_case(csil_pkg::CSIL_OP_RLC, 8'h00, 8'h80, 1'b0, 8'h00, 4'h1, 4'h1);
		alu_case(csil_pkg::CSIL_OP_RRC, 8'h00, 8'h01, 1'b1, 8'h80, 4'h1, 4'h1);
		alu_case(csil_pkg::CSIL_OP_INC, 8'h00, 8'hFF, 1'b0, 8'h00, 4'h4, 4'h4);
		alu_case(csil_pkg::CSIL_OP_DEC, 8'h00, 8'h01, 1'b0, 8'h00, 4'h4, 4'h4);
	endtask
	// event order: halt, clear, expiry, timer, converter, interrupt return
	task automatic t_status();
		reset_dut();
		ev(6'b100000);
		chk(flags[5:4], 2'b01);
		wr(8'h0A, 8'hFF);
		chk(flags, 8'h1F);
		ev(6'b001000);
		chk(flags[5:4], 2'b11);
		ev(6'b010000);
		chk(flags[5:4], 2'b00);
		wr(8'h0A, 8'h30);
		chk(flags, 8'h00);
	endtask
	task automatic t_timer();
		reset_dut();
		stall = 1'b1;
		wr(8'h0B, 8'h05);
		wr(8'h0A, 8'h03);
		ev(6'b000100);
		chk(ic, 8'h25);
		stall = 1'b0;
		wait_take(12'h008);
		chk(ic, 8'h04);
		chk(flags, 8'h03);
		ev(6'b000100);
		chk(ic, 8'h24);
		chk(wake, 12'h001);
	endtask
	task automatic t_priority();
		reset_dut();
		wr(8'h0B, 8'h0E);
		i_ext_irq_pin = 1'b0;
		ev(6'b000010);
		ev(6'b000100);
		chk(ic, 8'h7E);
		chk(wake, 12'h001);
		wr(8'h0B, 8'h7F);
		wait_take(12'h004);
		chk(ic, 8'h6E);
		wr(8'h0B, 8'h6F);
		wait_take(12'h008);
		ev(6'b000001);
		wait_take(12'h00C);
		chk(ic, 8'h0E);
		i_ext_irq_pin = 1'b1;
	endtask
	task automatic t_full();
		reset_dut();
		repeat (6) begin
			call = 1'b1;
			cyc(1);
			call = 1'b0;
			cyc(1);
		end
		wr(8'h0B, 8'h05);
		ev(6'b000100);
		cyc(4);
		chk(ic, 8'h25);
		pop = 1'b1;
		cyc(1);
		pop = 1'b0;
		wait_take(12'h008);
	endtask

	// ==========================================
	// verdict and main sequence
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		i_mclk = 1'b0;
		i_reset = 1'b1;
		i_ext_irq_pin = 1'b1;
		stall = 1'b0;
		call = 1'b0;
		pop = 1'b0;
		i_mem = '0;
		i_alu = '0;
		i_evt = '0;
		t_window();
		t_alu();
		t_status();
		t_timer();
		t_priority();
		t_full();
		print_verdict();
	end
endmodule

bind csil_core csil_core_props #(.RAM_DEPTH(RAM_DEPTH)) csil_core_props_inst (.i_mclk(i_mclk), .i_reset(i_reset),
	.i_mem(i_mem), .i_alu(i_alu), .i_evt(i_evt), .i_ext_irq_pin(i_ext_irq_pin), .i_stack_full(i_stack_full),
	.i_irq_slot(i_irq_slot), .o_rdata(o_rdata), .o_accumulator(o_accumulator), .o_core_flags(o_core_flags),
	.o_interrupt_control(o_interrupt_control), .o_skip(o_skip), .o_irq_take(o_irq_take),
	.o_irq_vector(o_irq_vector), .o_wake(o_wake));

`default_nettype wire
